// ### core/cop1_pkg.sv
// Purpose: Shared constants and types for the charger option word one block.
// Assumes: SMBus word protocol, one 16-bit option word at a single command code.
// Notes: Bits 6..0 are stored and read back but steer nothing here.
package cop1_pkg;

  localparam logic [7:0] CMD_OPT1 = 8'h30;
  localparam logic [15:0] OPT1_RESET = 16'h0211;
  localparam int WORD_W = 16;

  // Field positions
  localparam int BIT_BATT_MON = 15;
  localparam int BIT_THR_HI = 14;
  localparam int BIT_THR_LO = 13;
  localparam int BIT_SYS_PWR = 12;
  localparam int BIT_IN_SHUNT = 11;
  localparam int BIT_CHG_SHUNT = 10;
  localparam int BIT_PWR_GAIN = 9;
  localparam int BIT_RSVD8 = 8;
  localparam int BIT_COMPARATOR_REFERENCE_SELECT = 7;

  // Low-power throttle alert source codes
  localparam logic [1:0] THR_OFF = 2'h0;
  localparam logic [1:0] THR_DISCHG = 2'h1;
  localparam logic [1:0] THR_SYSV = 2'h2;
  localparam logic [1:0] THR_RSVD = 2'h3;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_MACK,
    ST_WAIT
  } cop1_state_t;

endpackage : cop1_pkg

// ### core/cop1_option_reg.sv
// Purpose: Storage and field decode of charger option word one.
// Assumes: wr_en is a one-cycle pulse carrying a whole word.
// Notes: All outputs are registered.
`timescale 1ns/10ps
module cop1_option_reg (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic low_power_mode,
  output logic [15:0] word_q,
  output logic batt_current_monitor_output_enable,
  output logic system_power_monitor_enable,
  output logic [1:0] lowpower_throttle_alert_select,
  output logic discharge_current_trigger,
  output logic system_voltage_trigger,
  output logic input_shunt_value_select,
  output logic charge_shunt_value_select,
  output logic power_monitor_gain_select,
  output logic comparator_reference_select
);

  typedef struct packed {
    logic [15:0] word;
    logic batt_en;
    logic sys_en;
    logic dis_trig;
    logic sysv_trig;
  } cop1_reg_state_t;

  cop1_reg_state_t s_q;
  cop1_reg_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (wr_en) begin
      s_d.word = wr_data;
    end
    // Low-power mode overrides both monitor enables
    s_d.batt_en = s_d.word[cop1_pkg::BIT_BATT_MON] & ~low_power_mode;
    s_d.sys_en = s_d.word[cop1_pkg::BIT_SYS_PWR] & ~low_power_mode;
    // Reserved code 11 behaves as disabled
    s_d.dis_trig = (s_d.word[cop1_pkg::BIT_THR_HI:cop1_pkg::BIT_THR_LO] ==
                    cop1_pkg::THR_DISCHG);
    s_d.sysv_trig = (s_d.word[cop1_pkg::BIT_THR_HI:cop1_pkg::BIT_THR_LO] ==
                     cop1_pkg::THR_SYSV);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{word: cop1_pkg::OPT1_RESET, batt_en: 1'b0, sys_en: 1'b0,
               dis_trig: 1'b0, sysv_trig: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign word_q = s_q.word;
  assign batt_current_monitor_output_enable = s_q.batt_en;
  assign system_power_monitor_enable = s_q.sys_en;
  assign lowpower_throttle_alert_select = s_q.word[cop1_pkg::BIT_THR_HI:cop1_pkg::BIT_THR_LO];
  assign discharge_current_trigger = s_q.dis_trig;
  assign system_voltage_trigger = s_q.sysv_trig;
  assign input_shunt_value_select = s_q.word[cop1_pkg::BIT_IN_SHUNT];
  assign charge_shunt_value_select = s_q.word[cop1_pkg::BIT_CHG_SHUNT];
  assign power_monitor_gain_select = s_q.word[cop1_pkg::BIT_PWR_GAIN];
  assign comparator_reference_select = s_q.word[cop1_pkg::BIT_COMPARATOR_REFERENCE_SELECT];

endmodule : cop1_option_reg

// ### core/cop1_top.sv
// Purpose: SMBus target holding charger option word one and driving its controls.
// Assumes: SCL and SDA inputs are synchronous to sys_clk and slow against it.
// Notes: Only command 30h is served; other commands are not acknowledged.
`timescale 1ns/10ps
module cop1_top #(
  // Target address; value is arbitrary
  parameter logic [6:0] DEV_ADDR = 7'h5a
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic smb_scl,
  input wire logic smb_sda_in,
  output logic smb_sda_out,
  output logic smb_sda_oe_n,
  input wire logic low_power_mode,
  output logic [15:0] option_word,
  output logic batt_current_monitor_output_enable,
  output logic system_power_monitor_enable,
  output logic [1:0] lowpower_throttle_alert_select,
  output logic discharge_current_trigger,
  output logic system_voltage_trigger,
  output logic input_shunt_value_select,
  output logic charge_shunt_value_select,
  output logic power_monitor_gain_select,
  output logic comparator_reference_select
);

  typedef struct packed {
    cop1_pkg::cop1_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [1:0] idx;
    logic rd;
    logic hit;
    logic ack;
    logic [7:0] lo_byte;
    logic [7:0] rd_hi;
    logic mnack;
    logic drive;
    logic wr_en;
    logic [15:0] wr_data;
    logic scl_q;
    logic sda_q;
  } cop1_bus_state_t;

  cop1_bus_state_t s_q;
  cop1_bus_state_t s_d;
  logic [15:0] word_q;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign scl_rise = smb_scl & ~s_q.scl_q;
  assign scl_fall = ~smb_scl & s_q.scl_q;
  assign start_seen = smb_scl & s_q.scl_q & s_q.sda_q & ~smb_sda_in;
  assign stop_seen = smb_scl & s_q.scl_q & ~s_q.sda_q & smb_sda_in;

  always_comb begin
    s_d = s_q;
    s_d.scl_q = smb_scl;
    s_d.sda_q = smb_sda_in;
    s_d.wr_en = 1'b0;
    if (stop_seen) begin
      s_d.state = cop1_pkg::ST_IDLE;
      s_d.drive = 1'b0;
    end else if (start_seen) begin
      // Repeated start keeps the command hit flag for a word read
      s_d.state = cop1_pkg::ST_RX;
      s_d.bitcnt = 4'h0;
      s_d.idx = 2'h0;
      s_d.drive = 1'b0;
    end else begin
      unique case (s_q.state)
        cop1_pkg::ST_IDLE: begin
          s_d.drive = 1'b0;
        end
        cop1_pkg::ST_WAIT: begin
          s_d.drive = 1'b0;
        end
        cop1_pkg::ST_RX: begin
          if (scl_rise && s_q.bitcnt != cop1_pkg::BITS_PER_BYTE) begin
            s_d.shreg = {s_q.shreg[6:0], smb_sda_in};
            s_d.bitcnt = s_q.bitcnt + 4'h1;
          end else if (scl_fall && s_q.bitcnt == cop1_pkg::BITS_PER_BYTE) begin
            s_d.state = cop1_pkg::ST_ACK;
            s_d.ack = 1'b0;
            unique case (s_q.idx)
              2'h0: begin
                if (s_q.shreg[7:1] == DEV_ADDR) begin
                  s_d.ack = 1'b1;
                  s_d.rd = s_q.shreg[0];
                  s_d.rd_hi = word_q[15:8];
                  s_d.lo_byte = word_q[7:0];
                  if (!s_q.shreg[0]) begin
                    s_d.hit = 1'b0;
                  end
                end
              end
              2'h1: begin
                s_d.hit = (s_q.shreg == cop1_pkg::CMD_OPT1);
                s_d.ack = (s_q.shreg == cop1_pkg::CMD_OPT1);
              end
              2'h2: begin
                s_d.lo_byte = s_q.shreg;
                s_d.ack = 1'b1;
              end
              2'h3: begin
                s_d.ack = 1'b1;
                s_d.wr_en = s_q.hit;
                s_d.wr_data = {s_q.shreg, s_q.lo_byte};
              end
            endcase
            s_d.drive = s_d.ack;
            if (!s_d.ack) begin
              s_d.state = cop1_pkg::ST_WAIT;
            end
          end
        end
        cop1_pkg::ST_ACK: begin
          if (scl_fall) begin
            s_d.bitcnt = 4'h0;
            if (s_q.rd && s_q.idx == 2'h0) begin
              // Read of a non-matching command returns zero
              s_d.state = cop1_pkg::ST_TX;
              s_d.shreg = s_q.hit ? s_q.lo_byte : 8'h00;
              s_d.rd_hi = s_q.hit ? s_q.rd_hi : 8'h00;
              s_d.drive = ~s_d.shreg[7];
              s_d.idx = 2'h2;
            end else if (s_q.idx == 2'h3) begin
              s_d.state = cop1_pkg::ST_WAIT;
              s_d.drive = 1'b0;
            end else begin
              s_d.state = cop1_pkg::ST_RX;
              s_d.drive = 1'b0;
              s_d.idx = s_q.idx + 2'h1;
            end
          end
        end
        cop1_pkg::ST_TX: begin
          if (scl_rise) begin
            s_d.bitcnt = s_q.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (s_q.bitcnt == cop1_pkg::BITS_PER_BYTE) begin
              s_d.state = cop1_pkg::ST_MACK;
              s_d.drive = 1'b0;
            end else begin
              s_d.shreg = {s_q.shreg[6:0], 1'b0};
              s_d.drive = ~s_q.shreg[6];
            end
          end
        end
        cop1_pkg::ST_MACK: begin
          if (scl_rise) begin
            s_d.mnack = smb_sda_in;
          end else if (scl_fall) begin
            s_d.bitcnt = 4'h0;
            if (!s_q.mnack && s_q.idx == 2'h2) begin
              s_d.state = cop1_pkg::ST_TX;
              s_d.shreg = s_q.rd_hi;
              s_d.drive = ~s_q.rd_hi[7];
              s_d.idx = 2'h3;
            end else begin
              s_d.state = cop1_pkg::ST_WAIT;
            end
          end
        end
        default: begin
          s_d.state = cop1_pkg::ST_IDLE;
          s_d.drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{state: cop1_pkg::ST_IDLE, bitcnt: 4'h0, shreg: 8'h00, idx: 2'h0,
               rd: 1'b0, hit: 1'b0, ack: 1'b0, lo_byte: 8'h00, rd_hi: 8'h00,
               mnack: 1'b1, drive: 1'b0, wr_en: 1'b0, wr_data: 16'h0000,
               scl_q: 1'b1, sda_q: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // Open drain: only ever pulls low
  assign smb_sda_out = 1'b0;
  assign smb_sda_oe_n = ~s_q.drive;
  assign option_word = word_q;

  cop1_option_reg u_reg (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(s_q.wr_en),
    .wr_data(s_q.wr_data),
    .low_power_mode(low_power_mode),
    .word_q(word_q),
    .batt_current_monitor_output_enable(batt_current_monitor_output_enable),
    .system_power_monitor_enable(system_power_monitor_enable),
    .lowpower_throttle_alert_select(lowpower_throttle_alert_select),
    .discharge_current_trigger(discharge_current_trigger),
    .system_voltage_trigger(system_voltage_trigger),
    .input_shunt_value_select(input_shunt_value_select),
    .charge_shunt_value_select(charge_shunt_value_select),
    .power_monitor_gain_select(power_monitor_gain_select),
    .comparator_reference_select(comparator_reference_select)
  );

endmodule : cop1_top

// ### test/cop1_host_model.sv
// Purpose: Host model driving SMBus word transfers.
// Assumes: SDA wire has a pull-up; SCL idles high.
// Notes: Each SCL phase of a data bit lasts three clocks.
`timescale 1ns/10ps
module cop1_host_model #(
  parameter logic [6:0] ADDR = 7'h5a
) (
  input wire logic sys_clk,
  input wire logic sda,
  output logic scl = 1'b1,
  output logic hsda = 1'b1,
  output logic rv,
  output logic [15:0] rd
);
  task automatic half;
    repeat (3) @(negedge sys_clk);
  endtask : half
  task automatic bit_io(input logic b, output logic r);
    hsda = b;
    half();
    scl = 1'b1;
    half();
    r = sda;
    scl = 1'b0;
  endtask : bit_io
  task automatic xfer(input logic [7:0] b, input logic m, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(m, a);
  endtask : xfer
  // Also serves as repeated start
  task automatic start;
    half();
    hsda = 1'b1;
    half();
    scl = 1'b1;
    half();
    hsda = 1'b0;
    half();
    scl = 1'b0;
  endtask : start
  task automatic stop;
    half();
    hsda = 1'b0;
    half();
    scl = 1'b1;
    half();
    hsda = 1'b1;
    half();
  endtask : stop
  task automatic wr_word(input logic [7:0] c, input logic [15:0] d);
    logic [7:0] r;
    start();
    xfer({ADDR, 1'b0}, 1'b1, r);
    xfer(c, 1'b1, r);
    xfer(d[7:0], 1'b1, r);
    xfer(d[15:8], 1'b1, r);
    stop();
  endtask : wr_word
  task automatic rd_word(input logic [7:0] c);
    logic [7:0] r;
    logic [7:0] lo;
    start();
    xfer({ADDR, 1'b0}, 1'b1, r);
    xfer(c, 1'b1, r);
    start();
    xfer({ADDR, 1'b1}, 1'b1, r);
    xfer(8'hff, 1'b0, lo);
    xfer(8'hff, 1'b1, r);
    stop();
    rd = {r, lo};
    rv = 1'b1;
    @(negedge sys_clk);
    rv = 1'b0;
  endtask : rd_word
endmodule : cop1_host_model

// ### test/cop1_assertions.sv
// Purpose: Port assertions for option word one.
// Assumes: Derived outputs lag low_power_mode by one clock.
// Notes: Bound into cop1_top.
`timescale 1ns/10ps
module cop1_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic smb_sda_oe_n,
  input wire logic low_power_mode,
  input wire logic [15:0] option_word,
  input wire logic batt_current_monitor_output_enable,
  input wire logic system_power_monitor_enable,
  input wire logic [1:0] lowpower_throttle_alert_select,
  input wire logic discharge_current_trigger,
  input wire logic system_voltage_trigger,
  input wire logic input_shunt_value_select,
  input wire logic charge_shunt_value_select,
  input wire logic power_monitor_gain_select,
  input wire logic comparator_reference_select
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  a_reset_word: assert property ($fell(rst) |-> option_word == 16'h0211)
    else $error("word not at default");
  a_batt_gate: assert property (batt_current_monitor_output_enable ==
    (option_word[15] && !$past(low_power_mode))) else $error("batt enable wrong");
  a_sys_gate: assert property (system_power_monitor_enable ==
    (option_word[12] && !$past(low_power_mode))) else $error("sys enable wrong");
  a_low_power_off: assert property (low_power_mode |=>
    !batt_current_monitor_output_enable && !system_power_monitor_enable)
    else $error("monitor on in low power");
  a_throttle_map: assert property (lowpower_throttle_alert_select == option_word[14:13]
    && discharge_current_trigger == (option_word[14:13] == 2'h1)
    && system_voltage_trigger == (option_word[14:13] == 2'h2)) else $error("throttle wrong");
  a_shunt_map: assert property (input_shunt_value_select == option_word[11]
    && charge_shunt_value_select == option_word[10]) else $error("shunt select wrong");
  a_gain_ref_map: assert property (power_monitor_gain_select == option_word[9]
    && comparator_reference_select == option_word[7]) else $error("gain or ref wrong");
  a_write_at_ack: assert property (!$stable(option_word) |-> !smb_sda_oe_n)
    else $error("word changed outside ack");
endmodule : cop1_chk
bind cop1_top cop1_chk chk_u (.*);

// ### test/testbench.sv
// Purpose: Self-checking bench for option word one.
// Assumes: Host model holds the bus; bench drives low power.
// Notes: Readbacks are queued and compared on arrival.
`timescale 1ns/10ps
module testbench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic lpm = 1'b0;
  logic scl, hsda, oe_n, sda_o, rv;
  logic [15:0] word, rd;
  logic [9:0] o;
  logic [15:0] q[$];
  logic [31:0] seed = 32'h64a7;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  wire sda = hsda & (oe_n | sda_o);
  cop1_top dut_u (.sys_clk(sys_clk), .rst(rst), .smb_scl(scl), .smb_sda_in(sda),
    .smb_sda_out(sda_o), .smb_sda_oe_n(oe_n), .low_power_mode(lpm), .option_word(word),
    .batt_current_monitor_output_enable(o[9]), .system_power_monitor_enable(o[8]),
    .lowpower_throttle_alert_select(o[7:6]), .discharge_current_trigger(o[5]),
    .system_voltage_trigger(o[4]), .input_shunt_value_select(o[3]),
    .charge_shunt_value_select(o[2]), .power_monitor_gain_select(o[1]),
    .comparator_reference_select(o[0]));
  cop1_host_model host_u (.sys_clk(sys_clk), .sda(sda), .scl(scl), .hsda(hsda), .rv(rv),
    .rd(rd));
  initial forever #20 sys_clk = ~sys_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  always @(posedge sys_clk) if (rv === 1'b1) check(rd, q.pop_front());
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    logic [15:0] w;
    logic [9:0] e;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    q.push_back(16'h0211);
    host_u.rd_word(8'h30);
    check({6'h0, o}, 16'h0002);
    check(word, 16'h0211);
    $display("reset defaults done");
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      w = seed[15:0];
      // Each throttle code in turn; the low-power passes force both monitor bits on
      w[14:13] = i[1:0];
      w[15] = w[15] | i[2];
      w[12] = w[12] | i[2];
      lpm = i[2];
      host_u.wr_word(8'h30, w);
      q.push_back(w);
      host_u.rd_word(8'h30);
      e = {w[15] & ~i[2], w[12] & ~i[2], w[14:13], w[14:13] == 2'h1, w[14:13] == 2'h2,
        w[11], w[10], w[9], w[7]};
      check({6'h0, o}, {6'h0, e});
      check(word, w);
    end
    $display("field decode done");
    host_u.wr_word(8'h31, 16'hffff);
    q.push_back(w);
    host_u.rd_word(8'h30);
    q.push_back(16'h0);
    host_u.rd_word(8'h31);
    repeat (2) @(negedge sys_clk);
    $display("unmapped command done");
    // Reset in mid-run must bring back the defaults over written values
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    q.push_back(16'h0211);
    host_u.rd_word(8'h30);
    check(word, 16'h0211);
    check({6'h0, o}, 16'h0002);
    $display("mid-run reset done");
    close_out();
  end
endmodule : testbench
